// >>> common/sfs_params.svh
// constants of the stack start-up and fault sequencer
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
// register offsets
`define SFS_ADDR_CFG1 4'h0
`define SFS_ADDR_CFG3 4'h1
`define SFS_ADDR_STATUS 4'h2
`define SFS_ADDR_STATE 4'h3
// config_reg_one fields
`define SFS_CFG1_DRAIN_BIT 0
`define SFS_CFG1_FPWM_BIT 1
`define SFS_CFG1_SPREAD_BIT 2
`define SFS_CFG1_SWEN_BIT 3
`define SFS_CFG1_RESET 8'h08
// config_reg_three fields
`define SFS_CFG3_SINGLE_BIT 0
`define SFS_CFG3_RESET 8'h00
// status fields
`define SFS_STAT_HEAT_BIT 0
`define SFS_STAT_STOP_BIT 1
// timing
`define SFS_CLK_HZ 10000000
`define SFS_INIT_US 400
`define SFS_INIT_CYC ((`SFS_INIT_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_DEGLITCH_US 40
`define SFS_DEGLITCH_CYC ((`SFS_DEGLITCH_US * (`SFS_CLK_HZ / 1000000)))
`define SFS_SOFT_US 200
`define SFS_SOFT_CYC ((`SFS_SOFT_US * (`SFS_CLK_HZ / 1000000)))
// chain phase offset in degrees, fraction of a switching period
`define SFS_PHASE_DEG 140
`define SFS_PERIOD_CYC 10
`define SFS_PHASE_CYC ((`SFS_PHASE_DEG * `SFS_PERIOD_CYC) / 360)
`endif

// >>> common/sfs_pkg.sv
// types of the stack start-up and fault sequencer
package sfs_pkg;
	typedef enum logic [2:0] {
		SFS_INIT = 3'b000,
		SFS_STANDBY = 3'b001,
		SFS_WAIT_GO = 3'b010,
		SFS_SOFT = 3'b011,
		SFS_RUN = 3'b100,
		SFS_HOT = 3'b101
	} sfs_state_t;
endpackage : sfs_pkg

// >>> common/sfs_sync_if.sv
// synchronised comparator, uvlo and shared-line levels between the top and its synchroniser
`timescale 1ns/10ps
interface sfs_sync_if;
	logic over_warn;
	logic below_release_warn;
	logic over_stop;
	logic below_release_stop;
	logic out_low;
	logic out_high;
	logic uvlo;
	logic go_in;
	logic good_in;
	modport producer (output over_warn, below_release_warn, over_stop,
		below_release_stop, out_low, out_high, uvlo, go_in, good_in);
	modport consumer (input over_warn, below_release_warn, over_stop,
		below_release_stop, out_low, out_high, uvlo, go_in, good_in);
endinterface : sfs_sync_if

// >>> src/sfs_sync.sv
// two-flop synchronisers for the temperature, window, uvlo and shared-line inputs; current limit and the chain pin are not synchronised
`timescale 1ns/10ps
module sfs_sync #(
	parameter int WIDTH = 9
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] raw,
	sfs_sync_if.producer sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// ****************************************
	// two stages per bit
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= raw[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign sync.over_warn = sync_q[0];
	assign sync.below_release_warn = sync_q[1];
	assign sync.over_stop = sync_q[2];
	assign sync.below_release_stop = sync_q[3];
	assign sync.out_low = sync_q[4];
	assign sync.out_high = sync_q[5];
	assign sync.uvlo = sync_q[6];
	assign sync.go_in = sync_q[7];
	assign sync.good_in = sync_q[8];
endmodule : sfs_sync

// >>> src/sfs_sequencer.sv
// stack start-up, role, clock chain and thermal fault sequencer
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "sfs_params.svh"
module sfs_sequencer
	import sfs_pkg::*;
#(
	parameter int INIT_CYC = `SFS_INIT_CYC,
	parameter int DEGLITCH_CYC = `SFS_DEGLITCH_CYC,
	parameter int SOFT_CYC = `SFS_SOFT_CYC,
	parameter int PHASE_CYC = `SFS_PHASE_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic temp_over_warn,
	input wire logic temp_below_warn_release,
	input wire logic temp_over_stop,
	input wire logic temp_below_stop_release,
	input wire logic out_below_window,
	input wire logic out_above_window,
	input wire logic supply_uvlo,
	input wire logic current_limit,
	input wire logic chain_pin_in,
	output logic chain_pin_out,
	output logic chain_pin_oe,
	input wire logic chain_clk_in,
	input wire logic go_line_in,
	output logic go_line_out,
	output logic go_line_oe,
	input wire logic good_flag_line_in,
	output logic good_flag_line_out,
	output logic good_flag_line_oe,
	output logic loop_clamp,
	output logic loop_active,
	output logic switching_on,
	output logic discontinuous_switching,
	output logic forced_pwm,
	output logic spread_clocking,
	output logic output_drain_on,
	output logic window_enable,
	output logic serial_enable,
	output logic voltage_ramping_enable,
	output logic role_secondary
);
	// ****************************************
	// input synchronisers
	// ****************************************
	sfs_sync_if sy ();
	sfs_sync #(.WIDTH(9)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.raw({good_flag_line_in, go_line_in, supply_uvlo,
			out_above_window, out_below_window, temp_below_stop_release,
			temp_over_stop, temp_below_warn_release, temp_over_warn}),
		.sync(sy)
	);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] cfg1_q;
	logic [7:0] cfg3_q;
	logic heat_q;
	logic stop_q;
	logic sec_q;
	logic pulldown_latch_q;
	logic mode_hold_latch_q;
	logic good_prev_q;
	logic [15:0] cnt_q;
	logic [15:0] dg_q;
	logic window_ok_q;
	sfs_state_t st_q;
	logic hot;
	logic stat_rd;
	logic single_mode;

	assign stat_rd = reg_rd && (reg_addr == `SFS_ADDR_STATUS);
	assign hot = (st_q == SFS_HOT);
	assign single_mode = cfg3_q[`SFS_CFG3_SINGLE_BIT];

	// serial writes ignored in secondary role
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg1_q <= `SFS_CFG1_RESET;
			cfg3_q <= `SFS_CFG3_RESET;
		end else if (reg_wr && !sec_q) begin
			if (reg_addr == `SFS_ADDR_CFG1)
				cfg1_q <= reg_wdata;
			if (reg_addr == `SFS_ADDR_CFG3)
				cfg3_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SFS_ADDR_CFG1: reg_rdata <= cfg1_q;
				`SFS_ADDR_CFG3: reg_rdata <= cfg3_q;
				`SFS_ADDR_STATUS: reg_rdata <= {6'h00, stop_q, heat_q};
				`SFS_ADDR_STATE: reg_rdata <= {3'h0, mode_hold_latch_q,
					sec_q, st_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************
	// thermal status flags, set wins over read
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			heat_q <= 1'b0;
		else if (sy.over_warn)
			heat_q <= 1'b1;
		else if (stat_rd && sy.below_release_warn)
			heat_q <= 1'b0;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			stop_q <= 1'b0;
		else if (sy.over_stop)
			stop_q <= 1'b1;
		else if (stat_rd && sy.below_release_stop)
			stop_q <= 1'b0;
	end

	// ****************************************
	// start-up sequence
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= SFS_INIT;
			cnt_q <= 16'h0000;
		end else begin
			unique case (st_q)
				SFS_INIT: begin
					if (cnt_q == 16'(INIT_CYC - 1)) begin
						st_q <= SFS_STANDBY;
						cnt_q <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				SFS_STANDBY: begin
					if (sy.over_stop)
						st_q <= SFS_HOT;
					else if (cfg1_q[`SFS_CFG1_SWEN_BIT] && !sy.uvlo)
						st_q <= SFS_SOFT;
					cnt_q <= 16'h0000;
				end
				SFS_SOFT: begin
					if (sy.over_stop) begin
						st_q <= SFS_HOT;
					end else if (cnt_q == 16'(SOFT_CYC - 1)) begin
						st_q <= SFS_WAIT_GO;
						cnt_q <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				SFS_WAIT_GO: begin
					if (sy.over_stop)
						st_q <= SFS_HOT;
					else if (sy.go_in)
						st_q <= SFS_RUN;
				end
				SFS_RUN: begin
					if (sy.over_stop)
						st_q <= SFS_HOT;
					else if (sy.uvlo || !cfg1_q[`SFS_CFG1_SWEN_BIT]
						|| !sy.go_in)
						st_q <= SFS_STANDBY;
				end
				SFS_HOT: begin
					cnt_q <= 16'h0000;
					if (sy.below_release_stop)
						st_q <= SFS_SOFT;
				end
				default: st_q <= SFS_INIT;
			endcase
		end
	end

	// role caught after reset release from the chain pin
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			sec_q <= 1'b0;
		else if (st_q == SFS_INIT && cnt_q == 16'(INIT_CYC - 1))
			sec_q <= !chain_pin_in;
	end

	// ****************************************
	// secondary latches
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulldown_latch_q <= 1'b1;
			mode_hold_latch_q <= 1'b1;
			good_prev_q <= 1'b0;
		end else begin
			good_prev_q <= sy.good_in;
			if (st_q == SFS_INIT) begin
				pulldown_latch_q <= 1'b1;
				mode_hold_latch_q <= 1'b1;
			end else if (st_q == SFS_SOFT && cnt_q == 16'(SOFT_CYC - 1)) begin
				pulldown_latch_q <= 1'b0;
			end
			if (st_q != SFS_INIT && sy.good_in && !good_prev_q)
				mode_hold_latch_q <= 1'b0;
		end
	end

	// ****************************************
	// window comparator with deglitch, primary only
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dg_q <= 16'h0000;
			window_ok_q <= 1'b0;
		end else if (sec_q || sy.out_low || sy.out_high) begin
			dg_q <= 16'h0000;
			window_ok_q <= 1'b0;
		end else if (dg_q == 16'(DEGLITCH_CYC - 1)) begin
			window_ok_q <= 1'b1;
		end else begin
			dg_q <= dg_q + 16'h0001;
		end
	end

	// ****************************************
	// clock chain, delayed copy of the input edge
	// ****************************************
	logic [PHASE_CYC:0] chain_dly_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			chain_dly_q <= '0;
		else
			chain_dly_q <= {chain_dly_q[PHASE_CYC-1:0], chain_clk_in};
	end

	// pin is not driven during init so the strap can be read
	assign chain_pin_oe = (st_q != SFS_INIT);
	assign chain_pin_out = chain_dly_q[PHASE_CYC];

	// ****************************************
	// shared lines and outputs
	// ****************************************
	logic go_pull;
	logic good_pull;
	// current limit has no part in the go line
	assign go_pull = (st_q == SFS_INIT) || (st_q == SFS_SOFT)
		|| (st_q == SFS_STANDBY && sy.uvlo)
		|| (hot && !single_mode);
	assign go_line_out = 1'b0;
	assign go_line_oe = go_pull;

	assign good_pull = sec_q ? pulldown_latch_q
		: ((st_q != SFS_RUN) || !window_ok_q);
	assign good_flag_line_out = 1'b0;
	assign good_flag_line_oe = good_pull;

	assign loop_clamp = !sec_q && !sy.go_in;
	assign loop_active = !sec_q && sy.go_in;
	assign switching_on = (st_q == SFS_SOFT) || (st_q == SFS_WAIT_GO)
		|| (st_q == SFS_RUN);
	assign discontinuous_switching = sec_q && mode_hold_latch_q;
	assign forced_pwm = sec_q || cfg1_q[`SFS_CFG1_FPWM_BIT];
	assign spread_clocking = !sec_q && cfg1_q[`SFS_CFG1_SPREAD_BIT];
	assign output_drain_on = (sec_q || cfg1_q[`SFS_CFG1_DRAIN_BIT])
		&& (hot || st_q == SFS_STANDBY);
	assign window_enable = !sec_q;
	assign serial_enable = !sec_q;
	assign voltage_ramping_enable = !sec_q;
	assign role_secondary = sec_q;

	// ****************************************
	// checks
	// ****************************************
	chk_heat_set: assert property (@(posedge clock) disable iff (!rstn)
		sy.over_warn |=> heat_q) else $error("heat flag not set");
	chk_heat_hold: assert property (@(posedge clock) disable iff (!rstn)
		(heat_q && stat_rd && !sy.below_release_warn && !sy.over_warn)
		|=> heat_q) else $error("heat flag cleared early");
	chk_stop_hold: assert property (@(posedge clock) disable iff (!rstn)
		(stop_q && !sy.below_release_stop && !sy.over_stop) |=> stop_q)
		else $error("stop flag cleared early");
	chk_hot_enter: assert property (@(posedge clock) disable iff (!rstn)
		(sy.over_stop && st_q != SFS_INIT) |=> (hot && !switching_on))
		else $error("no shutdown");
	chk_hot_go: assert property (@(posedge clock) disable iff (!rstn)
		hot |-> (go_line_oe == !single_mode)) else $error("go pull");
	chk_hot_good: assert property (@(posedge clock) disable iff (!rstn)
		(hot && !sec_q) |-> good_flag_line_oe) else $error("good");
	chk_hot_exit: assert property (@(posedge clock) disable iff (!rstn)
		(hot && sy.below_release_stop) |=> (st_q == SFS_SOFT))
		else $error("no restart");
	chk_sec_drain: assert property (@(posedge clock) disable iff (!rstn)
		(sec_q && hot) |-> output_drain_on) else $error("drain");
	chk_loop_clamp: assert property (@(posedge clock) disable iff (!rstn)
		!sec_q |-> ((loop_clamp == !$past(go_line_in, 2))
		&& (loop_active == $past(go_line_in, 2))))
		else $error("loop");
	chk_dcm_edge: assert property (@(posedge clock) disable iff (!rstn)
		(st_q != SFS_INIT && $rose(sy.good_in)) |=> !mode_hold_latch_q)
		else $error("mode hold kept");
endmodule : sfs_sequencer

// >>> testbench/sfs_peer.sv
// peer converter model: shared open-drain lines, strap and chain clock
`timescale 1ns/10ps
module sfs_peer (
	input wire logic clock,
	input wire logic rstn,
	input wire logic strap_sec,
	input wire logic hold_go,
	input wire logic hold_good,
	input wire logic go_line_oe,
	input wire logic good_flag_line_oe,
	input wire logic chain_pin_oe,
	input wire logic chain_pin_out,
	output logic go_line_in,
	output logic good_flag_line_in,
	output logic chain_pin_in,
	output logic chain_clk_in
);
	logic [2:0] div_q;
	// ****************************************
	// wired lines, pulled up when released
	// ****************************************
	assign go_line_in = !(go_line_oe || hold_go);
	assign good_flag_line_in = !(good_flag_line_oe || hold_good);
	// an open strap reads high through the weak pull inside the device
	assign chain_pin_in = chain_pin_oe ? chain_pin_out : !strap_sec;
	// upstream clock, one switching period shared by the whole stack
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_q <= 3'h0;
			chain_clk_in <= 1'b0;
		end else begin
			div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
			if (div_q == 3'h4)
				chain_clk_in <= !chain_clk_in;
		end
	end
endmodule : sfs_peer

// >>> testbench/test_stack_startup_fault_sequencer.sv
// self-checking bench of the stack start-up and fault sequencer
`timescale 1ns/10ps
`include "sfs_params.svh"
module test_stack_startup_fault_sequencer;
	import sfs_pkg::*;
	localparam int PH = 3;
	logic clock, rstn, reg_wr, reg_rd, strap_sec, hold_go, hold_good;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] hist;
	logic temp_over_warn, temp_below_warn_release, temp_over_stop;
	logic temp_below_stop_release, out_below_window, out_above_window;
	logic supply_uvlo, current_limit, chain_pin_in, chain_pin_out;
	logic chain_pin_oe, chain_clk_in, go_line_in, go_line_out, go_line_oe;
	logic good_flag_line_in, good_flag_line_out, good_flag_line_oe;
	logic loop_clamp, loop_active, switching_on, discontinuous_switching;
	logic forced_pwm, spread_clocking, output_drain_on, window_enable;
	logic serial_enable, voltage_ramping_enable, role_secondary;
	int miscompares, checks;
	sfs_sequencer #(.INIT_CYC(20), .SOFT_CYC(10), .DEGLITCH_CYC(8),
		.PHASE_CYC(PH)) u_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .temp_over_warn, .temp_below_warn_release,
		.temp_over_stop, .temp_below_stop_release, .out_below_window,
		.out_above_window, .supply_uvlo, .current_limit, .chain_pin_in,
		.chain_pin_out, .chain_pin_oe, .chain_clk_in, .go_line_in,
		.go_line_out, .go_line_oe, .good_flag_line_in, .good_flag_line_out,
		.good_flag_line_oe, .loop_clamp, .loop_active, .switching_on,
		.discontinuous_switching, .forced_pwm, .spread_clocking,
		.output_drain_on, .window_enable, .serial_enable,
		.voltage_ramping_enable, .role_secondary);
	sfs_peer u_peer (.clock, .rstn, .strap_sec, .hold_go, .hold_good,
		.go_line_oe, .good_flag_line_oe, .chain_pin_oe, .chain_pin_out,
		.go_line_in, .good_flag_line_in, .chain_pin_in, .chain_clk_in);
	initial begin
		clock = 1'b0;
		forever #50 clock = !clock;
	end
	always_ff @(posedge clock)
		hist <= {hist[14:0], chain_clk_in};
	// ****************************************
	// shared helpers
	// ****************************************
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk8(input string what, input logic [7:0] exp, got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8
	task automatic chk1(input string what, input logic exp, got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask : chk1
	task automatic look(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : look
	function automatic logic pick(input int sel);
		case (sel)
			0: return go_line_oe;
			1: return loop_active;
			2: return discontinuous_switching;
			default: return good_flag_line_oe;
		endcase
	endfunction : pick
	task automatic wait_sig(input int sel, input logic val);
		for (int i = 0; i < 300; i++) begin
			look(1);
			if (pick(sel) === val)
				return;
		end
		miscompares++;
		$display("Error wait %0d expected %b seen %b", sel, val, pick(sel));
		tally_and_finish();
	endtask : wait_sig
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e, string w);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk8(w, e, reg_rdata);
	endtask : rd
	task automatic do_reset(input logic sec);
		rstn <= 1'b0;
		strap_sec <= sec;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
	endtask : do_reset
	task automatic s_chain();
		chk1("chain driven", 1'b1, chain_pin_oe);
		repeat (20) begin
			look(1);
			chk1("chain phase", hist[PH], chain_pin_out);
		end
	endtask : s_chain
	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_primary();
		do_reset(1'b0);
		look(1);
		chk1("go pull init", 1'b1, go_line_oe);
		chk1("good pull init", 1'b1, good_flag_line_oe);
		chk1("chain oe init", 1'b0, chain_pin_oe);
		chk1("go out level", 1'b0, go_line_out);
		chk1("good out level", 1'b0, good_flag_line_out);
		rd(`SFS_ADDR_CFG1, `SFS_CFG1_RESET, "cfg1 reset");
		rd(`SFS_ADDR_CFG3, `SFS_CFG3_RESET, "cfg3 reset");
		rd(`SFS_ADDR_STATUS, 8'h00, "status reset");
		rd(4'hF, 8'h00, "unmapped");
		wait_sig(0, 1'b0);
		chk1("role", 1'b0, role_secondary);
		chk1("clamp go low", 1'b1, loop_clamp);
		chk1("idle go low", 1'b0, loop_active);
		@(posedge clock);
		hold_go <= 1'b0;
		wait_sig(1, 1'b1);
		chk1("clamp off", 1'b0, loop_clamp);
		chk1("window on", 1'b1, window_enable);
		wr(`SFS_ADDR_CFG1, 8'h0F);
		rd(`SFS_ADDR_CFG1, 8'h0F, "cfg1 write");
		chk1("fpwm", 1'b1, forced_pwm);
		chk1("spread", 1'b1, spread_clocking);
		wait_sig(3, 1'b0);
		out_below_window <= 1'b1;
		wait_sig(3, 1'b1);
		out_below_window <= 1'b0;
		wait_sig(3, 1'b0);
		out_above_window <= 1'b1;
		wait_sig(3, 1'b1);
		out_above_window <= 1'b0;
		s_chain();
		current_limit <= 1'b1;
		look(8);
		chk1("go kept in limit", 1'b0, go_line_oe);
		current_limit <= 1'b0;
		supply_uvlo <= 1'b1;
		wait_sig(0, 1'b1);
		wait_sig(1, 1'b0);
		supply_uvlo <= 1'b0;
		wait_sig(1, 1'b1);
	endtask : s_primary
	task automatic s_thermal();
		temp_over_warn <= 1'b1;
		temp_below_warn_release <= 1'b0;
		look(6);
		rd(`SFS_ADDR_STATUS, 8'h01, "heat set");
		rd(`SFS_ADDR_STATUS, 8'h01, "heat kept");
		wr(`SFS_ADDR_CFG1, 8'h09);
		temp_over_stop <= 1'b1;
		temp_below_stop_release <= 1'b0;
		wait_sig(0, 1'b1);
		chk1("stop switching", 1'b0, switching_on);
		chk1("drain hot", 1'b1, output_drain_on);
		chk1("good low hot", 1'b1, good_flag_line_oe);
		rd(`SFS_ADDR_STATUS, 8'h03, "stop set");
		rd(`SFS_ADDR_STATUS, 8'h03, "stop kept");
		temp_over_stop <= 1'b0;
		temp_below_stop_release <= 1'b1;
		temp_over_warn <= 1'b0;
		wait_sig(1, 1'b1);
		chk1("switching again", 1'b1, switching_on);
		chk1("go released", 1'b0, go_line_oe);
		rd(`SFS_ADDR_STATUS, 8'h03, "flags held");
		rd(`SFS_ADDR_STATUS, 8'h01, "stop clear");
		temp_below_warn_release <= 1'b1;
		look(4);
		rd(`SFS_ADDR_STATUS, 8'h01, "heat held");
		rd(`SFS_ADDR_STATUS, 8'h00, "heat clear");
		wr(`SFS_ADDR_CFG3, 8'h01);
		wr(`SFS_ADDR_CFG1, 8'h08);
		temp_over_stop <= 1'b1;
		temp_below_stop_release <= 1'b0;
		look(6);
		chk1("single no go pull", 1'b0, go_line_oe);
		chk1("no drain", 1'b0, output_drain_on);
		chk1("stop single", 1'b0, switching_on);
		temp_over_stop <= 1'b0;
		temp_below_stop_release <= 1'b1;
		look(4);
		rd(`SFS_ADDR_STATUS, 8'h02, "stop single");
		rd(`SFS_ADDR_STATUS, 8'h00, "stop single clear");
	endtask : s_thermal
	task automatic s_secondary();
		do_reset(1'b1);
		hold_good <= 1'b1;
		look(2);
		chk1("good pull init", 1'b1, good_flag_line_oe);
		rd(`SFS_ADDR_STATE, 8'h10, "latch init");
		wait_sig(3, 1'b0);
		chk1("dcm init", 1'b1, discontinuous_switching);
		chk1("secondary", 1'b1, role_secondary);
		chk1("forced pwm", 1'b1, forced_pwm);
		chk1("no window", 1'b0, window_enable);
		chk1("no serial", 1'b0, serial_enable);
		chk1("no ramp", 1'b0, voltage_ramping_enable);
		chk1("no spread", 1'b0, spread_clocking);
		wr(`SFS_ADDR_CFG1, 8'h00);
		rd(`SFS_ADDR_CFG1, `SFS_CFG1_RESET, "write ignored");
		look(10);
		chk1("dcm line low", 1'b1, discontinuous_switching);
		hold_good <= 1'b0;
		wait_sig(2, 1'b0);
		s_chain();
		supply_uvlo <= 1'b1;
		look(6);
		chk1("drain forced", 1'b1, output_drain_on);
	endtask : s_secondary
	initial begin
		{rstn, reg_wr, reg_rd, hold_good, strap_sec} = 5'h00;
		{temp_over_warn, temp_over_stop, current_limit} = 3'h0;
		{out_below_window, out_above_window, supply_uvlo} = 3'h0;
		{temp_below_warn_release, temp_below_stop_release, hold_go} = 3'h7;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		miscompares = 0;
		checks = 0;
		s_primary();
		s_thermal();
		s_secondary();
		tally_and_finish();
	end
endmodule : test_stack_startup_fault_sequencer
